// ---- design/pch_pkg.sv ----
// package: offsets, field layouts and reset values of the header registers
package pch_pkg;
    // register offsets inside the controller register view
    localparam logic [15:0] OFF_CLASS_REV = 16'hD008;
    localparam logic [15:0] OFF_CFG_ONE = 16'hD00C;
    localparam logic [15:0] OFF_WIN0_LOW = 16'hD010;
    localparam logic [15:0] OFF_WIN0_HIGH = 16'hD014;
    localparam logic [15:0] OFF_WIN1_LOW = 16'hD018;
    // matching pci configuration space offsets
    localparam logic [7:0] CFG_OFF_WIN0 = 8'h10;
    localparam logic [7:0] CFG_OFF_WIN1 = 8'h18;
    // reset values
    localparam logic [23:0] CLASS_RESET = 24'h060000;
    localparam logic [7:0] REVISION_RESET = 8'h00; // arbitrary value
    localparam logic [6:0] LAYOUT_RESET = 7'h00;
    localparam logic [7:0] TENURE_RESET = 8'h00;
    localparam logic [7:0] LINE_SIZE_RESET = 8'h00;
    // window base field widths (512 MB and 16 MB windows)
    localparam int WIN0_BITS = 3;
    localparam int WIN1_BITS = 8;
    localparam logic [2:0] WIN0_RESET = 3'h0;
    localparam logic [7:0] WIN1_RESET = 8'h00;
    // fixed low nibble of a window base: prefetchable, 32-bit, memory
    localparam logic [3:0] WIN_LOW_NIBBLE = 4'h8;
    // field positions
    localparam int POS_CLASS = 8;
    localparam int POS_LAYOUT = 16;
    localparam int POS_TENURE = 8;
    localparam int POS_WIN0 = 29;
    localparam int POS_WIN1 = 24;
    localparam logic [1:0] TENURE_LOW_ZERO = 2'h0;
    // burst read command choice driven by line size
    typedef enum logic [1:0] {
        PCH_RD_LINE_NONE,
        PCH_RD_LINE,
        PCH_RD_MULTIPLE
    } pch_rd_cmd_type;
    localparam logic [7:0] LINE_MULTI_MIN = 8'h08;
    localparam logic [2:0] EE_LOAD_CYCLES = 3'h1;
endpackage : pch_pkg

// ---- design/pch_ee_if.sv ----
// interface: eeprom load strobes carried into the header register bank
`timescale 1ns/1ps
interface pch_ee_if;
    logic load;
    logic [23:0] class_value;
    logic [7:0] revision_value;
    logic [6:0] layout_value;
    modport source (output load, output class_value,
        output revision_value, output layout_value);
    modport sink (input load, input class_value,
        input revision_value, input layout_value);
endinterface : pch_ee_if

// ---- design/pch_win_match.sv ----
// module: window hit decode for both inbound memory windows
`timescale 1ns/1ps
module pch_win_match
    import pch_pkg::*;
(
    // window bases
    input wire logic [WIN0_BITS-1:0] win0_base,
    input wire logic [WIN1_BITS-1:0] win1_base,
    // inbound address and enable
    input wire logic [31:0] addr,
    input wire logic valid,
    input wire logic mem_enable,
    // hits
    output logic hit0,
    output logic hit1
);
    // decode is purely on the high address bits; size is fixed per window
    always_comb begin
        hit0 = valid && mem_enable
            && (addr[31:POS_WIN0] == win0_base);
        hit1 = valid && mem_enable
            && (addr[31:POS_WIN1] == win1_base);
    end
endmodule : pch_win_match

// ---- design/pch_ee_latch.sv ----
// module: captures eeprom load data into a strobe bundle
`timescale 1ns/1ps
module pch_ee_latch
    import pch_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // raw eeprom side
    input wire logic ee_valid,
    input wire logic [31:0] ee_class_rev,
    input wire logic [6:0] ee_layout,
    // bundle to the register bank
    pch_ee_if.source ee
);
    // register the eeprom word once so the bank sees a clean strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ee.load <= 1'b0;
            ee.class_value <= CLASS_RESET;
            ee.revision_value <= REVISION_RESET;
            ee.layout_value <= LAYOUT_RESET;
        end else begin
            ee.load <= ee_valid;
            if (ee_valid) begin
                ee.class_value <= ee_class_rev[31:POS_CLASS];
                ee.revision_value <= ee_class_rev[7:0];
                ee.layout_value <= ee_layout;
            end
        end
    end
endmodule : pch_ee_latch

// ---- design/pch_regs.sv ----
// module: pci configuration header register bank, class to window 1
//
// Operation
// - no register access in subordinate mode
// - class field resets to host bridge
// - class read-only, eeprom loadable
// - revision read-only, eeprom loadable
// - self-test capable bit reads zero
// - multi-function flag reads zero
// - header layout resets zero, eeprom loadable
// - bus tenure timer writable, resets zero
// - tenure timer low two bits zero
// - line size writable, steers burst read
// - windows at config offsets 10 and 18
// - window 0 is 512 MB, bits 31:29
// - window 1 is 16 MB, bits 31:24
// - window bit 3 reads one
// - window bits 2:1 read zero
// - window bit 0 reads zero
// - no dual address; window 0 high unused
// - claim memory only when enabled
`timescale 1ns/1ps
module pch_regs
    import pch_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // mode and command bit from the command register
    input wire logic subordinate_mode,
    input wire logic memory_response_enable,
    // register access port
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_sel,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    // eeprom load
    input wire logic ee_valid,
    input wire logic [31:0] ee_class_rev,
    input wire logic [6:0] ee_layout,
    // inbound memory decode
    input wire logic [31:0] in_addr,
    input wire logic in_valid,
    output logic win0_hit,
    output logic win1_hit,
    // field outputs to the controller
    output logic [7:0] bus_tenure_timer,
    output pch_rd_cmd_type burst_rd_cmd
);
    import pch_pkg::*;

    pch_ee_if ee_bus ();
    logic [23:0] class_field;
    logic [7:0] revision_field;
    logic [6:0] header_layout_field;
    logic [7:0] line_size_field;
    logic [WIN0_BITS-1:0] win0_base;
    logic [WIN1_BITS-1:0] win1_base;
    logic hit0;
    logic hit1;
    logic access_ok;
    logic [15:0] eff_addr;
    logic [31:0] next_rdata;

    pch_ee_latch u_ee (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ee_valid(ee_valid),
        .ee_class_rev(ee_class_rev),
        .ee_layout(ee_layout),
        .ee(ee_bus.source)
    );

    pch_win_match u_match (
        .win0_base(win0_base),
        .win1_base(win1_base),
        .addr(in_addr),
        .valid(in_valid),
        .mem_enable(memory_response_enable),
        .hit0(hit0),
        .hit1(hit1)
    );

    // maps a config-space offset onto the register view offset
    function automatic logic [15:0] map_cfg(input logic [7:0] off);
        map_cfg = {8'hD0, off};
    endfunction : map_cfg

    // window base word: base bits high, fixed nibble low, rest zero
    function automatic logic [31:0] win_word(input logic [31:0] base);
        win_word = base | {28'h0000000, WIN_LOW_NIBBLE};
    endfunction : win_word

    // subordinate mode shuts this view off entirely
    assign access_ok = !subordinate_mode;
    // config host addresses by pci offset; both views land on one map
    assign eff_addr = cfg_sel ? map_cfg(cfg_addr) : reg_addr;

    // identification fields: bus cannot write, only eeprom may load
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            class_field <= CLASS_RESET;
            revision_field <= REVISION_RESET;
            header_layout_field <= LAYOUT_RESET;
        end else if (ee_bus.load) begin
            class_field <= ee_bus.class_value;
            revision_field <= ee_bus.revision_value;
            header_layout_field <= ee_bus.layout_value;
        end
    end

    // writable timing fields
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_tenure_timer <= TENURE_RESET;
            line_size_field <= LINE_SIZE_RESET;
        end else if (reg_wr && access_ok && eff_addr == OFF_CFG_ONE) begin
            // low bits forced so counts stay multiples of four
            bus_tenure_timer <= {reg_wdata[15:10], TENURE_LOW_ZERO};
            line_size_field <= reg_wdata[7:0];
        end
    end

    // window base fields; only the top bits are storage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            win0_base <= WIN0_RESET;
            win1_base <= WIN1_RESET;
        end else if (reg_wr && access_ok) begin
            if (eff_addr == OFF_WIN0_LOW)
                win0_base <= reg_wdata[31:POS_WIN0];
            if (eff_addr == OFF_WIN1_LOW)
                win1_base <= reg_wdata[31:POS_WIN1];
            // window 0 high has no storage, so a stray write is harmless
        end
    end

    // read mux; reserved and unused words give zero
    always_comb begin
        next_rdata = 32'h00000000;
        case (eff_addr)
            OFF_CLASS_REV: next_rdata = {class_field, revision_field};
            // bit 31 and bit 23 are constant zero
            OFF_CFG_ONE: next_rdata = {1'b0, 7'h00, 1'b0,
                header_layout_field, bus_tenure_timer, line_size_field};
            OFF_WIN0_LOW: next_rdata = win_word(
                {win0_base, 29'h00000000});
            OFF_WIN0_HIGH: next_rdata = 32'h00000000;
            OFF_WIN1_LOW: next_rdata = win_word(
                {win1_base, 24'h000000});
            default: next_rdata = 32'h00000000;
        endcase
    end

    // one-cycle ack; a blocked access still acks but reads zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= reg_rd || reg_wr;
            reg_rdata <= (reg_rd && access_ok) ? next_rdata
                : 32'h00000000;
        end
    end

    // registered window hits
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            win0_hit <= 1'b0;
            win1_hit <= 1'b0;
        end else begin
            win0_hit <= hit0;
            win1_hit <= hit1;
        end
    end

    // burst read command from line size: zero means plain reads
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            burst_rd_cmd <= PCH_RD_LINE_NONE;
        else if (line_size_field == 8'h00)
            burst_rd_cmd <= PCH_RD_LINE_NONE;
        else if (line_size_field < LINE_MULTI_MIN)
            burst_rd_cmd <= PCH_RD_LINE;
        else
            burst_rd_cmd <= PCH_RD_MULTIPLE;
    end

    // assertions: identification fields only move on an eeprom strobe
    AST_CLASS_RESET: assert property (
        @(posedge core_clk) $rose(rst_n)
        |-> class_field == CLASS_RESET || ee_bus.load)
        else $error("class field not at host bridge value after reset");
    AST_CLASS_RO: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !ee_bus.load |=> $stable(class_field))
        else $error("class field changed without eeprom load");
    AST_REV_RO: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !ee_bus.load |=> $stable(revision_field))
        else $error("revision changed without eeprom load");
    AST_LAYOUT_RO: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !ee_bus.load |=> $stable(header_layout_field))
        else $error("header layout changed without eeprom load");
    AST_EE_TAKE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ee_bus.load |=> class_field == $past(ee_bus.class_value))
        else $error("eeprom class value not taken");

    // assertions: register access and the fixed configuration word
    AST_BLOCKED_ACK: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd || reg_wr |=> reg_ack)
        else $error("access not acknowledged one cycle later");
    AST_CFG_FIXED: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && access_ok && eff_addr == OFF_CFG_ONE
        |=> reg_rdata[31:23] == 9'h000)
        else $error("self-test or multi-function bit read nonzero");
    AST_TENURE_LOW: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bus_tenure_timer[1:0] == TENURE_LOW_ZERO)
        else $error("tenure timer low bits nonzero");
    AST_TENURE_WR: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_wr && access_ok && eff_addr == OFF_CFG_ONE
        |=> bus_tenure_timer[7:2] == $past(reg_wdata[15:10]))
        else $error("tenure timer write not stored");
    AST_LINE_WR: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_wr && access_ok && eff_addr == OFF_CFG_ONE
        |=> line_size_field == $past(reg_wdata[7:0]))
        else $error("line size write not stored");
    // a blocked write must leave every writable field alone
    AST_WR_BLOCKED: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_wr && subordinate_mode
        |=> $stable(bus_tenure_timer) && $stable(line_size_field)
        && $stable(win0_base) && $stable(win1_base))
        else $error("write landed in subordinate mode");
    AST_BLOCKED: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && subordinate_mode |=> reg_rdata == 32'h00000000)
        else $error("read data leaked in subordinate mode");
    AST_MAP_CFG: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cfg_sel && (cfg_addr == CFG_OFF_WIN0 || cfg_addr == CFG_OFF_WIN1)
        |-> eff_addr == (cfg_addr == CFG_OFF_WIN0 ? OFF_WIN0_LOW
        : OFF_WIN1_LOW))
        else $error("config offset mapped to wrong register");

    // assertions: window base words
    AST_WIN_NIBBLE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && access_ok && (eff_addr == OFF_WIN0_LOW ||
        eff_addr == OFF_WIN1_LOW) |=> reg_rdata[3:0] == WIN_LOW_NIBBLE)
        else $error("window base low nibble wrong");
    AST_WIN0_RSVD: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && access_ok && eff_addr == OFF_WIN0_LOW
        |=> reg_rdata[28:4] == 25'h0000000)
        else $error("window 0 reserved bits nonzero");
    AST_WIN1_RSVD: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && access_ok && eff_addr == OFF_WIN1_LOW
        |=> reg_rdata[23:4] == 20'h00000)
        else $error("window 1 reserved bits nonzero");
    AST_WIN0_HIGH: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && eff_addr == OFF_WIN0_HIGH |=> reg_rdata == 32'h00000000)
        else $error("unused window 0 high word read nonzero");
    AST_WIN0_STORE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_wr && access_ok && eff_addr == OFF_WIN0_LOW
        |=> win0_base == $past(reg_wdata[31:29]))
        else $error("window 0 base write not stored");
    AST_WIN1_STORE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_wr && access_ok && eff_addr == OFF_WIN1_LOW
        |=> win1_base == $past(reg_wdata[31:24]))
        else $error("window 1 base write not stored");

    // assertions: inbound claim
    AST_NO_CLAIM: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !memory_response_enable |=> !win0_hit && !win1_hit)
        else $error("window claimed while memory response disabled");
    AST_WIN0_HIT: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        in_valid && memory_response_enable &&
        in_addr[31:POS_WIN0] == win0_base |=> win0_hit)
        else $error("window 0 hit missed");
    AST_WIN1_HIT: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        in_valid && memory_response_enable &&
        in_addr[31:POS_WIN1] == win1_base |=> win1_hit)
        else $error("window 1 hit missed");
    AST_WIN_MISS: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        in_valid && in_addr[31:POS_WIN0] != win0_base
        |=> !win0_hit)
        else $error("window 0 claimed on a foreign address");

    // assertions: burst command follows the line size one clock later
    AST_CMD_MULTI: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        line_size_field >= LINE_MULTI_MIN |=> burst_rd_cmd == PCH_RD_MULTIPLE)
        else $error("long line size did not select multiple reads");
    AST_CMD_NONE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        line_size_field == 8'h00 |=> burst_rd_cmd == PCH_RD_LINE_NONE)
        else $error("zero line size did not select plain reads");

    // covers for the main scenarios
    COV_WIN0_HIT: cover property (@(posedge core_clk) win0_hit);
    COV_WIN1_HIT: cover property (@(posedge core_clk) win1_hit);
    COV_EE_LOAD: cover property (@(posedge core_clk) ee_bus.load);
    COV_BLOCKED: cover property (@(posedge core_clk)
        reg_wr && subordinate_mode);
    COV_CMD_MULTI: cover property (@(posedge core_clk)
        burst_rd_cmd == PCH_RD_MULTIPLE);
endmodule : pch_regs

// ---- bench/pch_host_model.sv ----
// host model: drives register strobes and inbound memory addresses
`timescale 1ns/1ps
module pch_host_model (
    // clock
    input wire logic core_clk,
    // register access
    output logic reg_rd,
    output logic reg_wr,
    output logic [15:0] reg_addr,
    output logic [7:0] cfg_addr,
    output logic cfg_sel,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    // inbound memory
    output logic [31:0] in_addr,
    output logic in_valid,
    input wire logic win0_hit,
    input wire logic win1_hit
);
    // idle values at time zero
    initial begin
        {reg_rd, reg_wr, cfg_sel, in_valid} = 4'h0;
        {reg_addr, cfg_addr, reg_wdata, in_addr} = '0;
    end

    // one word access; released reg_addr and reg_wdata show inverted data, cfg_addr and cfg_sel keep a stale copy
    task automatic access(input logic wr, input logic sel,
        input logic [15:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic ok);
        int n;
        n = 0;
        rd = 32'h0;
        ok = 1'b1;
        if (wr && a == 16'hD014) return;
        @(negedge core_clk);
        {reg_rd, reg_wr, cfg_sel} = {!wr, wr, sel};
        {reg_addr, cfg_addr, reg_wdata} = {a, a[7:0], wd};
        @(posedge core_clk);
        @(negedge core_clk);
        {reg_rd, reg_wr} = 2'h0;
        {reg_addr, reg_wdata} = {~a, ~wd};
        while (reg_ack !== 1'b1 && n < 4) begin
            @(negedge core_clk);
            n++;
        end
        ok = (reg_ack === 1'b1);
        rd = reg_rdata;
    endtask : access

    // inbound address probe; hits are taken one cycle after valid
    task automatic probe(input logic [31:0] a, output logic [1:0] h);
        @(negedge core_clk);
        {in_addr, in_valid} = {a, 1'b1};
        @(posedge core_clk);
        @(negedge core_clk);
        {in_addr, in_valid} = {~a, 1'b0};
        h = {win1_hit, win0_hit};
    endtask : probe
endmodule : pch_host_model

// ---- bench/tb.sv ----
// testbench: header register bank with random and corner accesses
`timescale 1ns/1ps
module tb;
    import pch_pkg::*;
    logic core_clk, rst_n, subordinate_mode, memory_response_enable;
    logic reg_rd, reg_wr, cfg_sel, reg_ack, in_valid, win0_hit, win1_hit;
    logic ee_valid, ok;
    logic [15:0] reg_addr, a16;
    logic [7:0] cfg_addr, bus_tenure_timer, rev, ten, ls, w1;
    logic [31:0] reg_wdata, reg_rdata, ee_class_rev, in_addr, r, a;
    logic [6:0] ee_layout, lay;
    logic [23:0] class_exp;
    logic [2:0] w0;
    logic [1:0] h;
    pch_rd_cmd_type burst_rd_cmd;
    int error_cnt, num_checks, seed;
    logic [15:0] map [7] = '{16'hD008, 16'hD00C, 16'hD010, 16'hD014,
        16'hD018, 16'hD01C, 16'hD004};
    logic [7:0] lsv [5] = '{8'h00, 8'h01, 8'h07, 8'h08, 8'hFF};

    pch_regs uut (.core_clk, .rst_n, .subordinate_mode,
        .memory_response_enable, .reg_rd, .reg_wr, .reg_addr, .cfg_addr,
        .cfg_sel, .reg_wdata, .reg_rdata, .reg_ack, .ee_valid,
        .ee_class_rev, .ee_layout, .in_addr, .in_valid, .win0_hit,
        .win1_hit, .bus_tenure_timer, .burst_rd_cmd);
    pch_host_model host (.core_clk, .reg_rd, .reg_wr, .reg_addr,
        .cfg_addr, .cfg_sel, .reg_wdata, .reg_rdata, .reg_ack, .in_addr,
        .in_valid, .win0_hit, .win1_hit);

    // 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // expected register word from the shadow fields
    function automatic logic [31:0] exp_rd(input logic [15:0] ad);
        case (ad)
            16'hD008: return {class_exp, rev};
            16'hD00C: return {1'b0, 7'h00, 1'b0, lay, ten, ls};
            16'hD010: return {w0, 25'h0, 4'h8};
            16'hD018: return {w1, 20'h0, 4'h8};
            default: return 32'h0;
        endcase
    endfunction : exp_rd

    task automatic init_shadow;
        {class_exp, rev, lay} = {24'h060000, 8'h00, 7'h00};
        {ten, ls, w0, w1} = '0;
    endtask : init_shadow

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_data

    task automatic chk_flag(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_flag

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude

    // access by register offset or by config offset, chosen at random
    task automatic acc(input logic wr, input logic [15:0] ad,
        input logic [31:0] wd);
        host.access(wr, 1'($random(seed)), ad, wd, r, ok);
        if (!ok) begin
            error_cnt++;
            conclude();
        end
    endtask : acc

    task automatic rd_chk(input logic [15:0] ad);
        acc(1'b0, ad, 32'h0);
        chk_data(r, subordinate_mode ? 32'h0 : exp_rd(ad));
    endtask : rd_chk

    task automatic wr(input logic [15:0] ad, input logic [31:0] d);
        acc(1'b1, ad, d);
        if (!subordinate_mode && ad == 16'hD00C) {ten, ls} = {d[15:10],
            2'h0, d[7:0]};
        if (!subordinate_mode && ad == 16'hD010) w0 = d[31:29];
        if (!subordinate_mode && ad == 16'hD018) w1 = d[31:24];
    endtask : wr

    task automatic all_chk;
        foreach (map[i]) rd_chk(map[i]);
    endtask : all_chk

    task automatic outs_chk;
        // burst command trails the line size field by one clock
        @(negedge core_clk);
        chk_data({24'h0, bus_tenure_timer}, {24'h0, ten});
        chk_flag(burst_rd_cmd, ls == 8'h00 ? PCH_RD_LINE_NONE :
            (ls < 8'h08 ? PCH_RD_LINE : PCH_RD_MULTIPLE));
    endtask : outs_chk

    // main sequence
    initial begin
        {seed, error_cnt, num_checks} = {32'd40661, 32'd0, 32'd0};
        {rst_n, subordinate_mode, memory_response_enable, ee_valid} = 4'h0;
        {ee_class_rev, ee_layout} = '0;
        init_shadow();
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        all_chk();
        outs_chk();
        $display("test reset values done");
        for (int i = 0; i < 60; i++) begin
            a16 = map[{$random(seed)} % 7];
            wr(a16, $random(seed));
            rd_chk(a16);
            outs_chk();
        end
        foreach (lsv[i]) begin
            wr(16'hD00C, {16'h0, 8'hFF, lsv[i]});
            outs_chk();
        end
        $display("test random writes done");
        for (int i = 0; i < 90; i++) begin
            if (i % 30 == 0) memory_response_enable = !memory_response_enable;
            if (i % 10 == 0) wr(map[2 + 2 * (i % 20 / 10)], $random(seed));
            a = $random(seed);
            if (i % 3 == 0) a[31:29] = w0;
            if (i % 3 == 1) a[31:24] = w1;
            host.probe(a, h);
            chk_flag(h, {memory_response_enable && a[31:24] == w1,
                memory_response_enable && a[31:29] == w0});
        end
        $display("test window hits done");
        @(negedge core_clk);
        {ee_valid, ee_class_rev, ee_layout} = {1'b1, 32'($random(seed)),
            7'($random(seed))};
        @(negedge core_clk);
        ee_valid = 1'b0;
        repeat (3) @(negedge core_clk);
        {class_exp, rev, lay} = {ee_class_rev, ee_layout};
        all_chk();
        wr(16'hD008, $random(seed));
        rd_chk(16'hD008);
        $display("test eeprom load done");
        subordinate_mode = 1'b1;
        wr(16'hD010, 32'hFFFFFFFF);
        wr(16'hD00C, 32'hFFFFFFFF);
        rd_chk(16'hD010);
        @(negedge core_clk);
        subordinate_mode = 1'b0;
        all_chk();
        $display("test subordinate mode done");
        rst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        init_shadow();
        all_chk();
        outs_chk();
        $display("test second reset done");
        conclude();
    end
endmodule : tb
